// ---- hw/cec_count_clock.sv ----
`timescale 1ns/1ps
module cec_count_clock (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [11:0] i_div,
  output logic             o_tick
);
  import cec_tx_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
  } div_state_t;

  div_state_t r;
  div_state_t next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt >= i_div) begin
      next_r.cnt  = 12'h000;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 12'h001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_tick = r.tick;

endmodule : cec_count_clock

// ---- hw/cec_glitch_filter.sv ----
`timescale 1ns/1ps
module cec_glitch_filter (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  input  wire logic i_pin,
  output logic      o_level
);
  import cec_tx_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic [1:0] cnt;
    logic       level;
  } filt_state_t;

  filt_state_t r;
  filt_state_t next_r;

  always_comb begin
    next_r = r;
    next_r.sync = {r.sync[1:0], i_pin};
    // Stages 1 and 2 must agree; stage 0 is only read by stage 1
    // noise rejection
    if (r.sync[1] == r.sync[2] && r.sync[2] != r.level) begin
      if (i_tick) begin
        if (r.cnt + 2'd1 >= FILTER_TICKS) begin
          next_r.level = r.sync[2];
          next_r.cnt   = 2'd0;
        end else begin
          next_r.cnt = r.cnt + 2'd1;
        end
      end
    end else begin
      next_r.cnt = 2'd0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '{sync: 3'h7, cnt: 2'd0, level: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign o_level = r.level;

endmodule : cec_glitch_filter

// ---- hw/cec_tx.sv ----
`timescale 1ns/1ps
module cec_tx (
  input  wire logic                           i_mclk,
  input  wire logic                           i_rst_n,
  input  wire logic [cec_tx_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [cec_tx_pkg::DATA_W-1:0]  i_wr_data,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [cec_tx_pkg::DATA_W-1:0]  o_rd_data,
  input  wire logic                           i_cec,
  output logic                                o_cec_out,
  output logic                                o_cec_oe,
  output logic                                o_irq
);
  import cec_tx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    tx_fsm_t                st;
    logic [7:0]             ctl;
    logic [7:0]             tx_byte;
    logic [3:0]             idle_time;
    logic [11:0]            count_div;
    logic                   done_f;
    logic                   arb_f;
    logic                   ack_val;
    logic [7:0]             shreg;
    logic [3:0]             bit_idx;
    logic [7:0]             tick_cnt;
    logic [7:0]             free_cnt;
    logic [3:0]             free_bits;
    logic                   bus_prev;
    logic [1:0]             mis_cnt;
    logic                   drive_low;
    logic [DATA_W-1:0]      rd_data;
    logic                   irq;
  } tx_state_t;

  tx_state_t r;
  tx_state_t next_r;

  logic tick;
  logic bus;

  cec_count_clock u_count_clock (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_div   (r.count_div),
    .o_tick  (tick)
  );

  cec_glitch_filter u_filter (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_tick  (tick),
    .i_pin   (i_cec),
    .o_level (bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Waveform helpers

  function automatic logic [7:0] low_ticks(input logic [3:0] idx, input logic val);
    if (idx == BIT_IDX_START) begin
      low_ticks = START_LOW_TICKS;
    end else if (val) begin
      low_ticks = ONE_LOW_TICKS;
    end else begin
      low_ticks = ZERO_LOW_TICKS;
    end
  endfunction : low_ticks

  function automatic logic [7:0] total_ticks(input logic [3:0] idx);
    if (idx == BIT_IDX_START) begin
      total_ticks = START_TOTAL_TICKS;
    end else begin
      total_ticks = BIT_TOTAL_TICKS;
    end
  endfunction : total_ticks

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic       sending;
  logic       idle;
  logic       bit_val;
  logic [7:0] cur_low;
  logic [7:0] cur_total;
  logic       want_low;
  logic       settled;
  logic       mismatch;
  logic       set_done;
  logic       set_arb;
  logic       rd_status;

  always_comb begin
    next_r    = r;
    sending   = (r.st == ST_SEND);
    set_done  = 1'b0;
    set_arb   = 1'b0;
    rd_status = i_rd && (i_addr == OFS_STATUS);

    if (r.bit_idx == BIT_IDX_EOM) begin
      bit_val = r.ctl[CTL_EOM];
    end else if (r.bit_idx == BIT_IDX_ACK) begin
      bit_val = 1'b1;
    end else begin
      bit_val = r.shreg[7];
    end
    cur_low   = low_ticks(r.bit_idx, bit_val);
    cur_total = total_ticks(r.bit_idx);
    want_low  = sending && (r.tick_cnt < cur_low);
    // Skip the filter delay after each edge of our own
    settled   = (r.tick_cnt >= SETTLE_TICKS) &&
                !((r.tick_cnt >= cur_low) && (r.tick_cnt < cur_low + SETTLE_TICKS));
    mismatch  = (bus == r.drive_low);

    // quiet-time tracking, bit periods of silence
    next_r.bus_prev = bus;
    if (sending || (bus != r.bus_prev) || !bus) begin
      next_r.free_cnt  = 8'h00;
      next_r.free_bits = 4'h0;
    end else if (tick) begin
      if (r.free_cnt + 8'h01 >= BIT_TOTAL_TICKS) begin
        next_r.free_cnt = 8'h00;
        if (r.free_bits != 4'hF) begin
          next_r.free_bits = r.free_bits + 4'h1;
        end
      end else begin
        next_r.free_cnt = r.free_cnt + 8'h01;
      end
    end
    idle = (r.free_bits >= r.idle_time);

    // Register writes
    if (i_wr) begin
      if (i_addr == OFS_CONTROL) begin
        next_r.ctl = i_wr_data[7:0] & CTL_WR_MASK;
      end else if (i_addr == OFS_DATA) begin
        next_r.tx_byte = i_wr_data[7:0];
      end else if (i_addr == OFS_IDLE_TIME) begin
        next_r.idle_time = i_wr_data[3:0];
      end else if (i_addr == OFS_COUNT_DIV) begin
        next_r.count_div = i_wr_data[11:0];
      end
    end

    case (r.st)
      ST_IDLE: begin
        // write to data register launches a block
        if (i_wr && i_addr == OFS_DATA && r.ctl[CTL_TX_EN]) begin
          next_r.shreg    = i_wr_data[7:0];
          next_r.tick_cnt = 8'h00;
          next_r.mis_cnt  = 2'd0;
          if (r.ctl[CTL_START]) begin
            next_r.st = ST_WAIT;
          end else begin
            next_r.st      = ST_SEND;
            next_r.bit_idx = BIT_IDX_DATA0;
          end
        end
      end
      ST_WAIT: begin
        if (idle) begin
          next_r.st      = ST_SEND;
          next_r.bit_idx = BIT_IDX_START;
        end
      end
      ST_SEND: begin
        if (tick) begin
          // compare bus with own drive per tick
          if (r.bit_idx != BIT_IDX_ACK && settled && mismatch) begin
            next_r.mis_cnt = r.mis_cnt + 2'd1;
          end else begin
            next_r.mis_cnt = 2'd0;
          end
          if (r.bit_idx == BIT_IDX_ACK && r.tick_cnt == ACK_SAMPLE_TICKS) begin
            next_r.ack_val = bus;
          end
          if (r.mis_cnt + 2'd1 >= ARB_PERSIST_TICKS && r.bit_idx != BIT_IDX_ACK &&
              settled && mismatch) begin
            set_arb   = 1'b1;
            next_r.st = ST_IDLE;
          end else if (r.tick_cnt + 8'h01 >= cur_total) begin
            next_r.tick_cnt = 8'h00;
            if (r.bit_idx == BIT_IDX_ACK) begin
              set_done  = 1'b1;
              next_r.st = ST_IDLE;
            end else begin
              if (r.bit_idx != BIT_IDX_START) begin
                next_r.shreg = {r.shreg[6:0], 1'b0};
              end
              next_r.bit_idx = r.bit_idx + 4'h1;
            end
          end else begin
            next_r.tick_cnt = r.tick_cnt + 8'h01;
          end
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase

    // Status read clears done and arb, not ack; a new event in the same cycle wins
    if (rd_status) begin
      next_r.done_f = 1'b0;
      next_r.arb_f  = 1'b0;
    end
    if (set_done) begin
      next_r.done_f = 1'b1;
    end
    if (set_arb) begin
      next_r.arb_f = 1'b1;
    end

    // disable stops at once and clears status
    if (!next_r.ctl[CTL_TX_EN]) begin
      next_r.st      = ST_IDLE;
      next_r.done_f  = 1'b0;
      next_r.arb_f   = 1'b0;
      next_r.ack_val = 1'b0;
    end

    next_r.drive_low = want_low && (next_r.st == ST_SEND);

    // Read data live for exactly one cycle
    next_r.rd_data = '0;
    if (i_rd) begin
      if (i_addr == OFS_CONTROL) begin
        next_r.rd_data[7:0] = r.ctl;
      end else if (i_addr == OFS_DATA) begin
        next_r.rd_data[7:0] = r.tx_byte;
      end else if (i_addr == OFS_STATUS) begin
        next_r.rd_data[STS_ACK]     = r.ack_val;
        next_r.rd_data[STS_DONE]    = r.done_f;
        next_r.rd_data[STS_ARB]     = r.arb_f;
        next_r.rd_data[STS_SENDING] = sending;
      end else if (i_addr == OFS_IDLE_TIME) begin
        next_r.rd_data[3:0] = r.idle_time;
      end else if (i_addr == OFS_COUNT_DIV) begin
        next_r.rd_data[11:0] = r.count_div;
      end
    end

    next_r.irq = (next_r.done_f && next_r.ctl[CTL_DONE_IE]) ||
                 (next_r.arb_f && next_r.ctl[CTL_ARB_IE]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r           <= '0;
      r.st        <= ST_IDLE;
      r.ctl       <= CONTROL_RST;
      r.tx_byte   <= DATA_RST;
      r.idle_time <= IDLE_TIME_RST;
      r.count_div <= COUNT_DIV_RST;
      r.bus_prev  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_rd_data = r.rd_data;
  assign o_cec_out = 1'b0;
  assign o_cec_oe  = r.drive_low;
  assign o_irq     = r.irq;

endmodule : cec_tx

// ---- shared/cec_tx_pkg.sv ----
package cec_tx_pkg;

  localparam int CLK_HZ       = 125_000_000;
  localparam int COUNT_CLK_HZ = 32_000;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [2:0] OFS_CONTROL   = 3'h0;
  localparam logic [2:0] OFS_DATA      = 3'h1;
  localparam logic [2:0] OFS_STATUS    = 3'h2;
  localparam logic [2:0] OFS_IDLE_TIME = 3'h3;
  localparam logic [2:0] OFS_COUNT_DIV = 3'h4;

  // Control fields
  localparam int CTL_TX_EN   = 0;
  localparam int CTL_START   = 2;
  localparam int CTL_EOM     = 3;
  localparam int CTL_DONE_IE = 4;
  localparam int CTL_ARB_IE  = 5;
  localparam logic [7:0] CTL_WR_MASK = 8'h3D;

  // Status fields
  localparam int STS_ACK     = 0;
  localparam int STS_DONE    = 4;
  localparam int STS_ARB     = 5;
  localparam int STS_SENDING = 7;

  // Values after reset
  localparam logic [7:0]  CONTROL_RST   = 8'h00;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [3:0]  IDLE_TIME_RST = 4'h0;
  localparam logic [11:0] COUNT_DIV_RST = 12'(CLK_HZ / COUNT_CLK_HZ - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Bit waveform, in microseconds and in count clocks
  localparam int START_LOW_US   = 3700;
  localparam int START_TOTAL_US = 4500;
  localparam int BIT_TOTAL_US   = 2400;
  localparam int ZERO_LOW_US    = 1500;
  localparam int ONE_LOW_US     = 600;
  localparam int ACK_SAMPLE_US  = 1050;

  localparam logic [7:0] START_LOW_TICKS   = 8'(START_LOW_US * COUNT_CLK_HZ / 1_000_000);
  localparam logic [7:0] START_TOTAL_TICKS = 8'(START_TOTAL_US * COUNT_CLK_HZ / 1_000_000);
  localparam logic [7:0] BIT_TOTAL_TICKS   = 8'(BIT_TOTAL_US * COUNT_CLK_HZ / 1_000_000);
  localparam logic [7:0] ZERO_LOW_TICKS    = 8'(ZERO_LOW_US * COUNT_CLK_HZ / 1_000_000);
  localparam logic [7:0] ONE_LOW_TICKS     = 8'(ONE_LOW_US * COUNT_CLK_HZ / 1_000_000);
  localparam logic [7:0] ACK_SAMPLE_TICKS  = 8'(ACK_SAMPLE_US * COUNT_CLK_HZ / 1_000_000);

  localparam logic [1:0] FILTER_TICKS      = 2'd2;
  localparam logic [1:0] ARB_PERSIST_TICKS = 2'd2;
  localparam logic [7:0] SETTLE_TICKS      = 8'd4;

  localparam logic [3:0] BIT_IDX_START = 4'd0;
  localparam logic [3:0] BIT_IDX_DATA0 = 4'd1;
  localparam logic [3:0] BIT_IDX_EOM   = 4'd9;
  localparam logic [3:0] BIT_IDX_ACK   = 4'd10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } tx_fsm_t;

endpackage : cec_tx_pkg

// ---- tb/cec_partner.sv ----
`timescale 1ns/1ps
module cec_partner (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_bus,
  input  wire logic [3:0] i_target,
  output logic            o_pull
);
  logic       bus_q;
  logic [3:0] edges;
  logic [7:0] left;
  wire        fall = bus_q & ~i_bus;
  // Stretch the chosen low pulse to 48 ticks, past the sample point
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_q <= 1'b1;
      edges <= 4'h0;
      left  <= 8'h00;
    end else begin
      bus_q <= i_bus;
      edges <= (i_target == 4'h0) ? 4'h0 : edges + 4'(fall);
      left  <= (fall && edges + 4'h1 == i_target) ? 8'hC0 : left - 8'(left != 8'h00);
    end
  end
  assign o_pull = (left != 8'h00);
endmodule : cec_partner

// ---- tb/cec_tx_chk.sv ----
`timescale 1ns/1ps
module cec_tx_chk
  import cec_tx_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic              o_cec_out,
  input wire logic              o_cec_oe,
  input wire logic              o_irq
);
  logic tx_on;
  logic ie_any;
  // Shadow of the last control write, with the same latency as the design
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_on  <= 1'b0;
      ie_any <= 1'b0;
    end else if (i_wr && i_addr == OFS_CONTROL) begin
      tx_on  <= i_wr_data[CTL_TX_EN];
      ie_any <= i_wr_data[CTL_DONE_IE] | i_wr_data[CTL_ARB_IE];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence ctl_off;
    i_wr && i_addr == OFS_CONTROL && !i_wr_data[CTL_TX_EN];
  endsequence
  sequence sts_rd;
    i_rd && i_addr == OFS_STATUS;
  endsequence
  a_rd_quiet: assert property (!$past(i_rd) |-> o_rd_data == '0)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (i_rd && i_addr > OFS_COUNT_DIV |=> o_rd_data == '0)
    else $error("unmapped read not zero");
  a_ctl_reserved: assert property (i_rd && i_addr == OFS_CONTROL |=> o_rd_data[15:6] == '0 && !o_rd_data[1])
    else $error("reserved control bits read nonzero");
  a_read_drops_irq: assert property (sts_rd |-> ##[1:2] !o_irq)
    else $error("irq stays after status read");
  a_irq_needs_en: assert property (!ie_any [*3] |-> !o_irq)
    else $error("irq with both enables clear");
  a_disable_stops: assert property (ctl_off |-> ##[1:2] !o_cec_oe)
    else $error("drive continues after disable");
  a_off_no_drive: assert property (!tx_on [*3] |-> !o_cec_oe)
    else $error("bus driven while disabled");
  a_low_only: assert property (o_cec_out == 1'b0)
    else $error("pin drive value not low");
endmodule : cec_tx_chk

bind cec_tx cec_tx_chk cec_tx_chk_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .o_cec_out(o_cec_out), .o_cec_oe(o_cec_oe), .o_irq(o_irq));

// ---- tb/tb_cec_tx.sv ----
`timescale 1ns/1ps
module tb_cec_tx;
  import cec_tx_pkg::*;
  logic              i_mclk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wr_data = '0;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic [DATA_W-1:0] o_rd_data;
  logic              o_cec_oe;
  logic              o_irq;
  logic              pull;
  logic              glitch = 1'b0;
  logic [3:0]        target = 4'h0;
  logic              quiet = 1'b0;
  logic              rd_q = 1'b0;
  int                err_total = 0;
  int                n_compared = 0;
  int                run = 0;
  int                seed;
  logic [15:0]       r;
  logic [15:0]       rd_exp[$];
  logic [15:0]       rd_msk[$];
  logic [1:0]        bit_exp[$];
  // Pull-up bus: low if anyone pulls
  wire               cec_bus = ~o_cec_oe & ~pull & ~glitch;

  always #4 i_mclk = ~i_mclk;

  cec_tx cec_tx_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_cec(cec_bus), .o_cec_out(),
    .o_cec_oe(o_cec_oe), .o_irq(o_irq));
  cec_partner cec_partner_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(cec_bus),
    .i_target(target), .o_pull(pull));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bus(input logic rd, input logic [2:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wr_data <= d;
    i_rd <= rd;
    i_wr <= !rd;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    i_wr <= 1'b0;
  endtask : bus

  task automatic rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_exp.push_back(e & m);
    rd_msk.push_back(m);
    bus(1'b1, a, 16'h0000);
  endtask : rd

  task automatic wait_hi(ref logic s, input int lo, input int hi);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(posedge i_mclk);
      n++;
      if (n > hi) begin
        err_total++;
        finish_test();
      end
    end
    cmp("wait length", 16'h0001, 16'(n >= lo));
  endtask : wait_hi

  task automatic block(input logic st, input logic end_of_message_setting, input logic ack);
    logic [7:0] b;
    b = 8'($urandom);
    // Partner counts falls from zero; a zero target clears its count
    target <= 4'h0;
    if (st) bit_exp.push_back(2'd2);
    for (int i = 7; i >= 0; i--) bit_exp.push_back({1'b0, b[i]});
    bit_exp.push_back({1'b0, end_of_message_setting});
    bit_exp.push_back(2'd1);
    bus(1'b0, OFS_CONTROL, 16'h0011 | 16'(st) << CTL_START | 16'(end_of_message_setting) << CTL_EOM);
    // Header blocks see two extra falls, from the start bit and the idle-gap glitch
    target <= ack ? (st ? 4'hC : 4'hA) : 4'h0;
    // one-tick glitch in the idle gap must not restart the count
    if (st) fork
      begin
        repeat (100) @(posedge i_mclk);
        glitch <= 1'b1;
        repeat (4) @(posedge i_mclk);
        glitch <= 1'b0;
      end
    join_none
    bus(1'b0, OFS_DATA, {8'h00, b});
    wait_hi(o_cec_oe, st ? 616 : 0, st ? 1000 : 6);
    rd(OFS_STATUS, 16'h0080, 16'h0080);
    wait_hi(o_irq, 0, 6000);
    rd(OFS_STATUS, 16'h0010 | 16'(!ack), 16'h0031);
    rd(OFS_STATUS, 16'(!ack), 16'h0031);
    repeat (3) @(posedge i_mclk);
    cmp("irq", 16'h0000, 16'(o_irq));
  endtask : block

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  // Results watcher: read data and decoded pulse widths
  always @(posedge i_mclk) begin
    rd_q <= i_rd;
    if (rd_q) cmp("read data", rd_exp.pop_front(), o_rd_data & rd_msk.pop_front());
    if (o_cec_oe === 1'b1) begin
      run <= run + 1;
    end else if (run > 0) begin
      run <= 0;
      if (!quiet) cmp("bit", bit_exp.size() ? bit_exp.pop_front() : 2'd3,
                      run > 400 ? 2'd2 : (run > 134 ? 2'd0 : 2'd1));
    end
  end

  initial begin
    seed = $urandom(32'hFFA15681);
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(OFS_CONTROL, 16'(CONTROL_RST), 16'hFFFF);
    rd(OFS_DATA, 16'(DATA_RST), 16'hFFFF);
    rd(OFS_IDLE_TIME, 16'(IDLE_TIME_RST), 16'hFFFF);
    rd(OFS_COUNT_DIV, 16'(COUNT_DIV_RST), 16'hFFFF);
    rd(3'h7, 16'h0000, 16'hFFFF);
    bus(1'b0, OFS_STATUS, 16'hFFFF);
    rd(OFS_STATUS, 16'h0000, 16'hFFFF);
    r = 16'($urandom) & 16'hFFFE;
    bus(1'b0, OFS_CONTROL, r);
    rd(OFS_CONTROL, r & 16'(CTL_WR_MASK), 16'hFFFF);
    // Byte stored even while disabled
    bus(1'b0, OFS_DATA, 16'h00A5);
    rd(OFS_DATA, 16'h00A5, 16'hFFFF);
    bus(1'b0, OFS_COUNT_DIV, 16'h0003);
    bus(1'b0, OFS_IDLE_TIME, 16'h0003);
    block(1'b0, 1'b1, 1'b1);
    for (int m = 0; m < 4; m++) block(m[1], m[0], 1'($urandom));
    // Partner holds the first data bit low: lost arbitration
    target <= 4'h0;
    bit_exp.push_back(2'd1);
    bus(1'b0, OFS_CONTROL, 16'h0021);
    target <= 4'h1;
    bus(1'b0, OFS_DATA, 16'h0080 | 16'($urandom));
    wait_hi(o_irq, 0, 2000);
    bus(1'b0, OFS_CONTROL, 16'h0020);
    repeat (3) @(posedge i_mclk);
    cmp("irq", 16'h0000, 16'(o_irq));
    rd(OFS_STATUS, 16'h0000, 16'hFFFF);
    target <= 4'h0;
    repeat (300) @(posedge i_mclk);
    // Mid-frame disable truncates the pulse, so the watcher skips it
    quiet <= 1'b1;
    bus(1'b0, OFS_CONTROL, 16'h0001);
    bus(1'b0, OFS_DATA, 16'h0000);
    repeat (40) @(posedge i_mclk);
    bus(1'b0, OFS_CONTROL, 16'h0000);
    repeat (2) @(posedge i_mclk);
    cmp("drive", 16'h0000, 16'(o_cec_oe));
    repeat (400) @(posedge i_mclk);
    quiet <= 1'b0;
    cmp("bits left", 16'h0000, 16'(bit_exp.size()));
    finish_test();
  end
endmodule : tb_cec_tx
